// ===== src/pwr_mode_defines.vh
// Constants for the power-saving mode controller
// Notes on behaviour
// - After reset run in RUN mode from the master clock.
// - Slow mode steered by slow_select and two-bit slow_prescale_field.
// - Slow mode divides master clock by 2, 4, 8 or 16 for CPU and peripherals.
// - Wait-for-interrupt while in slow mode enters slow-wait, not plain wait.
// - Wait-for-interrupt stops the CPU clock, peripherals keep running.
// - Entering wait forces interrupt mask bits to 10; nothing else changes.
// - Wait lasts until interrupt or reset, then vector fetch of that source.
// - Wake interrupt pushes condition codes and sets mask to routine priority.
// - Halt instruction enters full halt if osc_irq_enable is 0, else timer-kept halt.
// - Timer-kept halt ends on time base, eligible interrupt or reset; no delay on interrupt.
// - Stabilisation delay leaving timer-kept halt only when the exit is a reset.
// - Entering timer-kept halt forces mask to 10b; pending interrupt wakes at once.
// - In timer-kept halt only oscillator and time base counter run.
// - Timer-kept halt with osc_irq_enable set never yields a watchdog reset.
// - Clearing osc_irq_enable during delay after interrupt exit drops into stabilise for the rest of the delay.
// - Leaving full halt restarts oscillator and waits 256 or 4096 cycles.
`ifndef PWR_MODE_DEFINES_VH
`define PWR_MODE_DEFINES_VH
`define MODE_RUN        3'h0
`define MODE_SLOW       3'h1
`define MODE_WAIT       3'h2
`define MODE_SLOW_WAIT  3'h3
`define MODE_ACT_HALT   3'h4
`define MODE_HALT       3'h5
`define MODE_STABILIZE  3'h6
`define MASK_ENABLE_ALL 2'h2
`define DELAY_SHORT     13'h0100
`define DELAY_LONG      13'h1000
`endif

// ===== src/slow_divider.v
// Master clock prescaler producing a one-cycle enable every 2, 4, 8 or 16 cycles
`timescale 1ns/10ps
`default_nettype none
module slow_divider
(
  input  wire       clock,
  input  wire       rst_n,
  input  wire [1:0] prescale,
  output wire       tick
);
  reg  [3:0] count_q;
  wire [3:0] last;

  assign last = (prescale == 2'h0) ? 4'h1 : (prescale == 2'h1) ? 4'h3 : (prescale == 2'h2) ? 4'h7 : 4'hf;
  assign tick = (count_q == last);

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      count_q <= 4'h0;
    else if (count_q >= last)
      count_q <= 4'h0;
    else
      count_q <= count_q + 4'h1;
  end
endmodule // slow_divider
`default_nettype wire

// ===== src/power_saving_mode_control.v
// Power-saving mode sequencer: run, slow, wait, halt variants and wake-up
`timescale 1ns/10ps
`include "pwr_mode_defines.vh"
`default_nettype none
module power_saving_mode_control
(
  input  wire       clock,
  input  wire       rst_n,
  input  wire       slow_select,
  input  wire [1:0] slow_prescale_field,
  input  wire       osc_irq_enable,
  input  wire       long_delay_opt,
  input  wire       wait_for_irq_instr,
  input  wire       halt_instr,
  input  wire       irq_pending,
  input  wire       halt_wake_irq,
  input  wire       time_base_irq,
  input  wire       active_halt_wake_irq,
  input  wire       soft_reset_req,
  input  wire       watchdog_expired,
  output reg  [2:0] mode_q,
  output reg        cpu_clk_en_q,
  output reg        periph_clk_en_q,
  output reg        time_base_clk_en_q,
  output reg        osc_on_q,
  output reg        force_mask_q,
  output reg  [1:0] forced_mask_q,
  output reg        wake_service_q,
  output reg        reset_vector_q,
  output reg        watchdog_reset_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Divider and stabilisation counter
  wire        slow_tick;
  reg  [12:0] delay_q;
  reg  [12:0] delay_d;
  reg         delay_is_reset_q;
  reg         delay_is_reset_d;
  reg  [2:0]  mode_d;
  reg         force_mask_d;
  reg         wake_service_d;
  reg         reset_vector_d;
  reg         osc_on_d;
  wire [12:0] delay_len;
  wire        in_slow;
  wire        wake_reset;

  slow_divider u_div
  (
    .clock    (clock),
    .rst_n    (rst_n),
    .prescale (slow_prescale_field),
    .tick     (slow_tick)
  );

  assign delay_len  = long_delay_opt ? `DELAY_LONG : `DELAY_SHORT;
  assign in_slow    = (mode_d == `MODE_SLOW) || (mode_d == `MODE_SLOW_WAIT);
  assign wake_reset = soft_reset_req;

  ////////////////////////////////////////////////////////////////////////////
  // Mode sequencing
  always @*
  begin
    mode_d           = mode_q;
    delay_d          = delay_q;
    delay_is_reset_d = delay_is_reset_q;
    force_mask_d     = 1'b0;
    wake_service_d   = 1'b0;
    reset_vector_d   = 1'b0;
    osc_on_d         = 1'b1;
    case (mode_q)
      `MODE_RUN, `MODE_SLOW:
      begin
        mode_d = slow_select ? `MODE_SLOW : `MODE_RUN;
        if (wait_for_irq_instr)
        begin
          mode_d       = (mode_q == `MODE_SLOW) ? `MODE_SLOW_WAIT : `MODE_WAIT;
          force_mask_d = 1'b1;
        end
        else if (halt_instr)
        begin
          force_mask_d = 1'b1;
          if (irq_pending)
            wake_service_d = 1'b1;
          else if (osc_irq_enable)
            mode_d = `MODE_ACT_HALT;
          else
          begin
            mode_d   = `MODE_HALT;
            osc_on_d = 1'b0;
          end
        end
      end
      `MODE_WAIT, `MODE_SLOW_WAIT:
      begin
        if (wake_reset)
        begin
          mode_d         = `MODE_RUN;
          reset_vector_d = 1'b1;
        end
        else if (irq_pending)
        begin
          mode_d         = (mode_q == `MODE_SLOW_WAIT) ? `MODE_SLOW : `MODE_RUN;
          wake_service_d = 1'b1;
        end
      end
      `MODE_ACT_HALT:
      begin
        if (wake_reset)
        begin
          mode_d           = `MODE_STABILIZE;
          delay_d          = delay_len;
          delay_is_reset_d = 1'b1;
        end
        else if (time_base_irq || active_halt_wake_irq)
        begin
          mode_d           = `MODE_RUN;
          wake_service_d   = 1'b1;
          delay_d          = delay_len;
          delay_is_reset_d = 1'b0;
        end
      end
      `MODE_HALT:
      begin
        osc_on_d = 1'b0;
        if (wake_reset || halt_wake_irq)
        begin
          mode_d           = `MODE_STABILIZE;
          osc_on_d         = 1'b1;
          delay_d          = delay_len;
          delay_is_reset_d = wake_reset;
        end
      end
      `MODE_STABILIZE:
      begin
        delay_d = delay_q - 13'h0001;
        if (delay_q == 13'h0001)
        begin
          mode_d         = `MODE_RUN;
          reset_vector_d = delay_is_reset_q;
          wake_service_d = ~delay_is_reset_q;
        end
      end
      default:
        mode_d = `MODE_RUN;
    endcase
    // Interrupt exit from timer-kept halt leaves a shadow delay running
    if ((mode_q == `MODE_RUN || mode_q == `MODE_SLOW) && delay_q != 13'h0000 && !halt_instr
        && !wait_for_irq_instr)
    begin
      delay_d = delay_q - 13'h0001;
      // Last count needs no stabilize pass; entering it at zero would wrap the counter
      if (!osc_irq_enable && delay_q != 13'h0001)
      begin
        mode_d           = `MODE_STABILIZE;
        delay_is_reset_d = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and clock gating
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q             <= `MODE_RUN;
      delay_q            <= 13'h0000;
      delay_is_reset_q   <= 1'b0;
      cpu_clk_en_q       <= 1'b1;
      periph_clk_en_q    <= 1'b1;
      time_base_clk_en_q <= 1'b1;
      osc_on_q           <= 1'b1;
      force_mask_q       <= 1'b0;
      forced_mask_q      <= `MASK_ENABLE_ALL;
      wake_service_q     <= 1'b0;
      reset_vector_q     <= 1'b0;
      watchdog_reset_q   <= 1'b0;
    end
    else
    begin
      mode_q           <= mode_d;
      delay_q          <= delay_d;
      delay_is_reset_q <= delay_is_reset_d;
      osc_on_q         <= osc_on_d;
      force_mask_q     <= force_mask_d;
      forced_mask_q    <= `MASK_ENABLE_ALL;
      wake_service_q   <= wake_service_d;
      reset_vector_q   <= reset_vector_d;
      // Enables change only at master clock edges so no runt pulse escapes
      case (mode_d)
        `MODE_RUN:
        begin
          cpu_clk_en_q    <= 1'b1;
          periph_clk_en_q <= 1'b1;
        end
        `MODE_SLOW:
        begin
          cpu_clk_en_q    <= slow_tick;
          periph_clk_en_q <= slow_tick;
        end
        `MODE_WAIT:
        begin
          cpu_clk_en_q    <= 1'b0;
          periph_clk_en_q <= 1'b1;
        end
        `MODE_SLOW_WAIT:
        begin
          cpu_clk_en_q    <= 1'b0;
          periph_clk_en_q <= slow_tick;
        end
        default:
        begin
          cpu_clk_en_q    <= 1'b0;
          periph_clk_en_q <= 1'b0;
        end
      endcase
      time_base_clk_en_q <= (mode_d != `MODE_HALT) && (mode_d != `MODE_STABILIZE) && (in_slow ? slow_tick : 1'b1);
      // Watchdog is masked while in timer-kept halt with osc_irq_enable set
      watchdog_reset_q <= watchdog_expired && !(mode_q == `MODE_ACT_HALT && osc_irq_enable);
    end
  end
endmodule // power_saving_mode_control
`default_nettype wire

// ===== testbench/pwr_mode_monitor.sv
// Checker for the power-saving mode controller ports
`timescale 1ns/10ps
`default_nettype none
module pwr_mode_monitor (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic osc_irq_enable,
  input wire logic long_delay_opt,
  input wire logic wait_for_irq_instr,
  input wire logic halt_instr,
  input wire logic irq_pending,
  input wire logic time_base_irq,
  input wire logic soft_reset_req,
  input wire logic [2:0] mode_q,
  input wire logic cpu_clk_en_q,
  input wire logic periph_clk_en_q,
  input wire logic time_base_clk_en_q,
  input wire logic osc_on_q,
  input wire logic force_mask_q,
  input wire logic [1:0] forced_mask_q,
  input wire logic wake_service_q,
  input wire logic watchdog_reset_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire run = mode_q == 3'h0;
  wire ahlt = mode_q == 3'h4;
  wait_entry_a: assert property (run && wait_for_irq_instr
    |=> mode_q == 3'h2 && force_mask_q && forced_mask_q == 2'h2 && !cpu_clk_en_q) else $error("bad wait entry");
  slow_wait_a: assert property (mode_q == 3'h1 && wait_for_irq_instr
    |=> mode_q == 3'h3) else $error("bad slow wait entry");
  wait_wake_a: assert property (mode_q == 3'h2 && irq_pending && !soft_reset_req
    |=> run && wake_service_q) else $error("bad wait wake");
  halt_select_a: assert property (run && halt_instr && !wait_for_irq_instr && !irq_pending
    |=> mode_q == ($past(osc_irq_enable) ? 3'h4 : 3'h5)) else $error("bad halt choice");
  halt_osc_a: assert property (mode_q == 3'h5
    |-> !osc_on_q && !cpu_clk_en_q) else $error("oscillator on in halt");
  active_clocks_a: assert property (ahlt
    |-> osc_on_q && time_base_clk_en_q && !cpu_clk_en_q && !periph_clk_en_q) else $error("bad halt clocks");
  active_wake_a: assert property (ahlt && time_base_irq && !soft_reset_req
    |=> run && wake_service_q) else $error("bad active halt wake");
  halt_refuse_a: assert property (run && halt_instr && !wait_for_irq_instr && irq_pending
    |=> run && wake_service_q) else $error("halt not refused");
  watchdog_mask_a: assert property ($past(ahlt && osc_irq_enable)
    |-> !watchdog_reset_q) else $error("watchdog reset in halt");
  stab_len_a: assert property ($past(mode_q) == 3'h5 && mode_q == 3'h6 && !long_delay_opt
    |-> ##255 mode_q == 3'h6 ##1 run) else $error("bad delay length");
  cover property (mode_q == 3'h3);
  cover property (ahlt ##1 run);
  cover property (mode_q == 3'h6 ##1 run);
endmodule // pwr_mode_monitor
bind power_saving_mode_control pwr_mode_monitor mon (.clock, .rst_n, .osc_irq_enable, .long_delay_opt,
  .wait_for_irq_instr, .halt_instr, .irq_pending, .time_base_irq, .soft_reset_req, .mode_q, .cpu_clk_en_q,
  .periph_clk_en_q, .time_base_clk_en_q, .osc_on_q, .force_mask_q, .forced_mask_q, .wake_service_q,
  .watchdog_reset_q);
`default_nettype wire

// ===== testbench/irq_source_model.sv
// Interrupt source model facing the mode controller
`timescale 1ns/10ps
`default_nettype none
module irq_source_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic raise,
  input wire logic wake_service_q,
  output var logic irq_pending
);
  // Request latch clears once the core takes the vector
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      irq_pending <= 1'b0;
    else if (raise)
      irq_pending <= 1'b1;
    else if (wake_service_q)
      irq_pending <= 1'b0;
endmodule // irq_source_model
`default_nettype wire

// ===== testbench/power_saving_mode_control_test.sv
// Self-checking bench for the power-saving mode controller
`timescale 1ns/10ps
`default_nettype none
module power_saving_mode_control_test;
  logic clock = 1'b0, rst_n = 1'b0, slow_select = 1'b0, osc_irq_enable = 1'b0, long_delay_opt = 1'b0;
  logic wait_for_irq_instr = 1'b0, halt_instr = 1'b0, halt_wake_irq = 1'b0, time_base_irq = 1'b0;
  logic soft_reset_req = 1'b0, watchdog_expired = 1'b0, raise = 1'b0, active_halt_wake_irq = 1'b0;
  logic [1:0] slow_prescale_field = 2'h0;
  wire logic irq_pending, cpu_clk_en_q, periph_clk_en_q, time_base_clk_en_q, osc_on_q, force_mask_q;
  wire logic wake_service_q, reset_vector_q, watchdog_reset_q;
  wire logic [2:0] mode_q;
  wire logic [1:0] forced_mask_q;
  int fails = 0, checks_done = 0, n;
  int per [4] = '{16, 8, 4, 2};
  always #25 clock = ~clock;
  power_saving_mode_control dut (.clock, .rst_n, .slow_select, .slow_prescale_field, .osc_irq_enable,
    .long_delay_opt, .wait_for_irq_instr, .halt_instr, .irq_pending, .halt_wake_irq, .time_base_irq,
    .active_halt_wake_irq, .soft_reset_req, .watchdog_expired, .mode_q, .cpu_clk_en_q, .periph_clk_en_q,
    .time_base_clk_en_q, .osc_on_q, .force_mask_q, .forced_mask_q, .wake_service_q, .reset_vector_q,
    .watchdog_reset_q);
  irq_source_model cpu (.clock, .rst_n, .raise, .wake_service_q, .irq_pending);
  task automatic tick(input int c);
    repeat (c) @(negedge clock);
  endtask
  task automatic chk(input string what, input logic [12:0] seen, input logic [12:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_mode(input logic [2:0] m);
    n = 0;
    while (mode_q !== m && n < 5000)
    begin
      tick(1);
      n++;
    end
    if (n == 5000)
    begin
      fails++;
      report_and_stop;
    end
  endtask
  task automatic instr(input logic w, input logic h);
    tick(2);
    wait_for_irq_instr = w;
    halt_instr = h;
    tick(1);
    wait_for_irq_instr = 1'b0;
    halt_instr = 1'b0;
  endtask
  task automatic irq;
    raise = 1'b1;
    tick(1);
    raise = 1'b0;
    tick(1);
  endtask
  initial
  begin
    tick(4);
    rst_n = 1'b1;
    chk("reset mode", mode_q, 3'h0);
    chk("reset clocks", {cpu_clk_en_q, periph_clk_en_q, time_base_clk_en_q, osc_on_q}, 4'hf);
    watchdog_expired = 1'b1;
    tick(1);
    chk("watchdog live", watchdog_reset_q, 1'b1);
    watchdog_expired = 1'b0;
    ////////////////////////////////////////////////////////////////
    // Slow prescale table: field against enable pulses in 32 cycles
    for (int f = 0; f < 4; f++)
    begin
      slow_select = 1'b1;
      slow_prescale_field = f[1:0];
      tick(20);
      n = 0;
      for (int i = 0; i < 32; i++)
      begin
        tick(1);
        n += (cpu_clk_en_q === 1'b1);
      end
      chk("slow ticks", n[12:0], per[f][12:0]);
      chk("slow mode", mode_q, 3'h1);
    end
    ////////////////////////////////////////////////////////////////
    instr(1'b1, 1'b0);
    chk("slow wait", mode_q, 3'h3);
    irq();
    chk("slow wake", wake_service_q, 1'b1);
    slow_select = 1'b0;
    wait_mode(3'h0);
    instr(1'b1, 1'b0);
    chk("wait", {mode_q, force_mask_q, forced_mask_q, cpu_clk_en_q, periph_clk_en_q}, 8'h59);
    irq();
    chk("wait wake", {mode_q, wake_service_q}, 4'h1);
    for (int o = 0; o < 2; o++)
    begin
      long_delay_opt = o[0];
      instr(1'b0, 1'b1);
      chk("halt", {mode_q, osc_on_q}, 4'ha);
      halt_wake_irq = 1'b1;
      tick(1);
      halt_wake_irq = 1'b0;
      wait_mode(3'h0);
      chk("halt delay", n[12:0], o ? 13'h1000 : 13'h0100);
      chk("halt wake", wake_service_q, 1'b1);
    end
    long_delay_opt = 1'b0;
    osc_irq_enable = 1'b1;
    instr(1'b0, 1'b1);
    chk("active halt", {mode_q, force_mask_q, forced_mask_q}, 6'h26);
    chk("active clocks", {cpu_clk_en_q, periph_clk_en_q, time_base_clk_en_q, osc_on_q}, 4'h3);
    watchdog_expired = 1'b1;
    tick(2);
    chk("watchdog", watchdog_reset_q, 1'b0);
    watchdog_expired = 1'b0;
    time_base_irq = 1'b1;
    tick(1);
    time_base_irq = 1'b0;
    chk("active wake", {mode_q, wake_service_q}, 4'h1);
    instr(1'b0, 1'b1);
    soft_reset_req = 1'b1;
    tick(1);
    soft_reset_req = 1'b0;
    wait_mode(3'h0);
    chk("reset delay", n[12:0], 13'h0100);
    chk("reset vector", reset_vector_q, 1'b1);
    irq();
    halt_instr = 1'b1;
    tick(1);
    halt_instr = 1'b0;
    chk("halt refused", {mode_q, wake_service_q}, 4'h1);
    ////////////////////////////////////////////////////////////////
    // Specific interrupt exit, then osc_irq_enable cleared inside the delay
    instr(1'b0, 1'b1);
    chk("second active halt", mode_q, 3'h4);
    active_halt_wake_irq = 1'b1;
    tick(1);
    active_halt_wake_irq = 1'b0;
    chk("specific wake", {mode_q, wake_service_q}, 4'h1);
    osc_irq_enable = 1'b0;
    tick(1);
    chk("early clear", mode_q, 3'h6);
    wait_mode(3'h0);
    chk("remaining delay", n[12:0], 13'h00ff);
    report_and_stop;
  end
endmodule // power_saving_mode_control_test
`default_nettype wire
